// [ssmc_pkg.sv]
// constants for the supply supervisor mode control block
package ssmc_pkg;

    // bus geometry
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFF_CORE_CTL = 8'h00;
    localparam logic [7:0] OFF_MAIN_CTL = 8'h04;
    localparam logic [7:0] OFF_MODE = 8'h08;
    localparam logic [7:0] OFF_LEVEL = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    // supervisor control field positions (same for both sides)
    localparam int F_SUP_EN = 0;
    localparam int F_SUP_MODE = 1;
    localparam int F_FAST_PERF = 2;
    localparam int F_MON_EN = 3;
    localparam int F_MON_FAST = 4;
    localparam int F_AUTO_CTL = 5;
    localparam int CFG_W = 6;

    // status field positions
    localparam int S_CORE_PEND = 0;
    localparam int S_MAIN_PEND = 1;
    localparam int S_WAKE_SLOW = 2;
    localparam int S_STUCK = 3;
    localparam int S_STATES = 4;
    localparam int S_MODE = 12;

    // reset values
    localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
    localparam logic [1:0] LEVEL_RESET = 2'h0;

    // supervisor / monitor states
    localparam logic [1:0] ST_OFF = 2'h0;
    localparam logic [1:0] ST_NORMAL = 2'h1;
    localparam logic [1:0] ST_FULL = 2'h2;

    // power modes
    localparam logic [2:0] PM_ACTIVE_RUN = 3'h0;
    localparam logic [2:0] PM_LIGHT_SLEEP0 = 3'h1;
    localparam logic [2:0] PM_LIGHT_SLEEP1 = 3'h2;
    localparam logic [2:0] PM_DEEP_SLEEP_TWO = 3'h3;
    localparam logic [2:0] PM_DEEP_SLEEP_THREE = 3'h4;
    localparam logic [2:0] PM_DEEP_SLEEP_FOUR = 3'h5;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int FAST_SETTLE_NS = 2000;
    localparam int NORM_SETTLE_NS = 150000;
    localparam int WAKE_WINDOW_NS = 1000;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] FAST_SETTLE_CYC =
        CNT_W'((FAST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] NORM_SETTLE_CYC =
        CNT_W'((NORM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WAKE_WINDOW_CYC =
        CNT_W'(WAKE_WINDOW_NS / CLK_PERIOD_NS);

    // sleep sequencer
    typedef enum logic [1:0] {PS_RUN, PS_DEEP, PS_STUCK} ssmc_ps_type;

endpackage

// [ssmc_top.sv]
// supply supervisor mode control with axi4-lite registers
`timescale 1ns/1ns
module ssmc_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ssmc_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ssmc_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // power events
    input wire logic wake_irq,
    input wire logic isr_sleep_req,
    input wire logic [2:0] isr_sleep_mode,
    input wire logic soft_power_up_clear,
    input wire logic core_voltage_ok,
    // supervisor status
    output logic [1:0][1:0] sup_state,
    output logic [1:0][1:0] mon_state,
    output logic [1:0] settle_pending,
    output logic wake_slow,
    output logic device_reset,
    output logic sleep_stuck,
    output logic [2:0] power_mode,
    output logic [1:0] core_level
);

    localparam int FAST_N = 50;
    localparam int NORM_N = 3750;

    logic aw_got;
    logic w_got;
    logic [ssmc_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_ok;
    logic wr_hit;
    logic [1:0] wr_cfg;
    logic wr_mode;
    logic wr_raise;
    logic [1:0][ssmc_pkg::CFG_W-1:0] cfg;
    logic [1:0][ssmc_pkg::CNT_W-1:0] cnt;
    logic level_rising;
    logic deep;
    logic [ssmc_pkg::CNT_W-1:0] win;
    logic risk;
    logic risky;
    logic main_drop;
    logic req;
    logic [2:0] req_mode;
    logic req_deep;
    logic slow_now;
    logic [31:0] status;
    logic [31:0] next_rdata;
    logic rd_hit;
    ssmc_pkg::ssmc_ps_type ps;

    function automatic logic [1:0] sup_map(
        input logic [ssmc_pkg::CFG_W-1:0] c,
        input logic in_deep
    );
        logic [1:0] awake;
        awake = c[ssmc_pkg::F_FAST_PERF] ? ssmc_pkg::ST_FULL
                                         : ssmc_pkg::ST_NORMAL;
        if (!c[ssmc_pkg::F_SUP_EN]) begin
            sup_map = ssmc_pkg::ST_OFF;
        end else if (!in_deep) begin
            sup_map = awake;
        end else if (!c[ssmc_pkg::F_AUTO_CTL]) begin
            sup_map = c[ssmc_pkg::F_SUP_MODE] ? awake : ssmc_pkg::ST_OFF;
        end else begin
            sup_map = (c[ssmc_pkg::F_SUP_MODE] && c[ssmc_pkg::F_FAST_PERF])
                      ? ssmc_pkg::ST_NORMAL : ssmc_pkg::ST_OFF;
        end
    endfunction

    function automatic logic [1:0] mon_map(
        input logic [ssmc_pkg::CFG_W-1:0] c,
        input logic in_deep
    );
        logic [1:0] awake;
        awake = c[ssmc_pkg::F_MON_FAST] ? ssmc_pkg::ST_FULL
                                        : ssmc_pkg::ST_NORMAL;
        if (!c[ssmc_pkg::F_MON_EN]) begin
            mon_map = ssmc_pkg::ST_OFF;
        end else if (!in_deep || !c[ssmc_pkg::F_AUTO_CTL]) begin
            mon_map = awake;
        end else begin
            mon_map = c[ssmc_pkg::F_MON_FAST] ? ssmc_pkg::ST_NORMAL
                                              : ssmc_pkg::ST_OFF;
        end
    endfunction

    // write decode
    assign wr_fire = aw_got && w_got && !bvalid;
    assign wr_ok = wr_fire && w_strb[0];
    assign wr_cfg[0] = wr_ok && aw_addr == ssmc_pkg::OFF_CORE_CTL;
    assign wr_cfg[1] = wr_ok && aw_addr == ssmc_pkg::OFF_MAIN_CTL;
    assign wr_mode = wr_ok && aw_addr == ssmc_pkg::OFF_MODE;
    assign wr_raise = wr_ok && aw_addr == ssmc_pkg::OFF_LEVEL
                      && w_data[1:0] > core_level;
    assign wr_hit = aw_addr == ssmc_pkg::OFF_CORE_CTL
                    || aw_addr == ssmc_pkg::OFF_MAIN_CTL
                    || aw_addr == ssmc_pkg::OFF_MODE
                    || aw_addr == ssmc_pkg::OFF_LEVEL
                    || aw_addr == ssmc_pkg::OFF_STATUS;

    // axi write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= ssmc_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_addr <= awaddr;
                aw_got <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data <= wdata;
                w_strb <= wstrb;
                w_got <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? ssmc_pkg::RESP_OKAY : ssmc_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // read mux
    always_comb begin
        status = '0;
        status[ssmc_pkg::S_CORE_PEND] = settle_pending[0];
        status[ssmc_pkg::S_MAIN_PEND] = settle_pending[1];
        status[ssmc_pkg::S_WAKE_SLOW] = wake_slow;
        status[ssmc_pkg::S_STUCK] = sleep_stuck;
        status[ssmc_pkg::S_STATES +: 8] = {mon_state[1], sup_state[1],
                                           mon_state[0], sup_state[0]};
        status[ssmc_pkg::S_MODE +: 3] = power_mode;
        next_rdata = '0;
        rd_hit = 1'b1;
        case (araddr)
            ssmc_pkg::OFF_CORE_CTL: next_rdata[5:0] = cfg[0];
            ssmc_pkg::OFF_MAIN_CTL: next_rdata[5:0] = cfg[1];
            ssmc_pkg::OFF_MODE: next_rdata[2:0] = power_mode;
            ssmc_pkg::OFF_LEVEL: next_rdata[1:0] = core_level;
            ssmc_pkg::OFF_STATUS: next_rdata = status;
            default: rd_hit = 1'b0;
        endcase
    end

    // axi read channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= ssmc_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= rd_hit ? ssmc_pkg::RESP_OKAY : ssmc_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // per-side configuration, settle timing and state mapping
    for (genvar i = 0; i < 2; i++) begin : g_side
        logic restart;
        logic fp_next;
        assign restart = wr_cfg[i] || (i == 0 && wr_raise);
        assign fp_next = wr_cfg[i] ? w_data[ssmc_pkg::F_FAST_PERF]
                                   : cfg[i][ssmc_pkg::F_FAST_PERF];

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cfg[i] <= ssmc_pkg::CFG_RESET;
            end else if (wr_cfg[i]) begin
                cfg[i] <= w_data[ssmc_pkg::CFG_W-1:0];
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                settle_pending[i] <= 1'b0;
                cnt[i] <= '0;
            end else if (restart) begin
                settle_pending[i] <= 1'b1;
                cnt[i] <= fp_next ? ssmc_pkg::FAST_SETTLE_CYC
                                  : ssmc_pkg::NORM_SETTLE_CYC;
            end else if (cnt[i] == 12'h001) begin
                settle_pending[i] <= 1'b0;
                cnt[i] <= '0;
            end else if (cnt[i] != '0) begin
                cnt[i] <= cnt[i] - 12'h001;
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sup_state[i] <= ssmc_pkg::ST_OFF;
                mon_state[i] <= ssmc_pkg::ST_OFF;
            end else begin
                sup_state[i] <= sup_map(cfg[i], deep);
                mon_state[i] <= mon_map(cfg[i], deep);
            end
        end
    end

    // core level and raise fault
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_level <= ssmc_pkg::LEVEL_RESET;
            level_rising <= 1'b0;
            device_reset <= 1'b0;
        end else begin
            device_reset <= 1'b0;
            if (wr_ok && aw_addr == ssmc_pkg::OFF_LEVEL) begin
                core_level <= w_data[1:0];
                level_rising <= wr_raise;
            end else if (cnt[0] == 12'h001 && !wr_cfg[0]) begin
                level_rising <= 1'b0;
                device_reset <= level_rising && !core_voltage_ok;
            end
        end
    end

    assign slow_now =
        (cfg[0][ssmc_pkg::F_SUP_EN] && !cfg[0][ssmc_pkg::F_FAST_PERF])
        || (cfg[0][ssmc_pkg::F_MON_EN] && !cfg[0][ssmc_pkg::F_MON_FAST]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_slow <= 1'b0;
        end else begin
            wake_slow <= slow_now;
        end
    end

    assign main_drop =
        (sup_map(cfg[1], 1'b0) == ssmc_pkg::ST_NORMAL
         && sup_map(cfg[1], 1'b1) == ssmc_pkg::ST_OFF)
        || (mon_map(cfg[1], 1'b0) == ssmc_pkg::ST_NORMAL
            && mon_map(cfg[1], 1'b1) == ssmc_pkg::ST_OFF);
    assign risky = (|settle_pending) || (!slow_now && main_drop);

    // one entry path for both sources
    assign req = wr_mode || isr_sleep_req;
    assign req_mode = wr_mode ? w_data[2:0] : isr_sleep_mode;
    assign req_deep = req_mode >= ssmc_pkg::PM_DEEP_SLEEP_TWO
                      && req_mode <= ssmc_pkg::PM_DEEP_SLEEP_FOUR;
    assign deep = ps != ssmc_pkg::PS_RUN;

    // sleep sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ps <= ssmc_pkg::PS_RUN;
            power_mode <= ssmc_pkg::PM_ACTIVE_RUN;
            sleep_stuck <= 1'b0;
            win <= '0;
            risk <= 1'b0;
        end else if (soft_power_up_clear) begin
            ps <= ssmc_pkg::PS_RUN;
            power_mode <= ssmc_pkg::PM_ACTIVE_RUN;
            sleep_stuck <= 1'b0;
            win <= '0;
        end else begin
            case (ps)
                ssmc_pkg::PS_RUN: begin
                    if (req && req_mode <= ssmc_pkg::PM_DEEP_SLEEP_FOUR) begin
                        power_mode <= req_mode;
                        if (req_deep) begin
                            ps <= ssmc_pkg::PS_DEEP;
                            win <= ssmc_pkg::WAKE_WINDOW_CYC;
                            risk <= risky;
                        end
                    end else if (wake_irq) begin
                        power_mode <= ssmc_pkg::PM_ACTIVE_RUN;
                    end
                end
                ssmc_pkg::PS_DEEP: begin
                    if (win != '0) begin
                        win <= win - 12'h001;
                    end
                    if (wake_irq) begin
                        if (win != '0 && risk) begin
                            ps <= ssmc_pkg::PS_STUCK;
                            sleep_stuck <= 1'b1;
                        end else begin
                            ps <= ssmc_pkg::PS_RUN;
                            power_mode <= ssmc_pkg::PM_ACTIVE_RUN;
                        end
                    end
                end
                ssmc_pkg::PS_STUCK: begin
                    sleep_stuck <= 1'b1;
                end
                default: begin
                    ps <= ssmc_pkg::PS_RUN;
                end
            endcase
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence deep_entry_s;
        ps == ssmc_pkg::PS_RUN && req && req_deep;
    endsequence

    sequence early_irq_s;
        ##[1:25] (ps == ssmc_pkg::PS_DEEP && wake_irq);
    endsequence

    fast_settle_a: assert property (
        wr_cfg[0] && w_data[ssmc_pkg::F_FAST_PERF]
        |=> settle_pending[0] && cnt[0] == 12'(FAST_N))
        else $error("fast settle delay not loaded");

    norm_settle_a: assert property (
        wr_cfg[0] && !w_data[ssmc_pkg::F_FAST_PERF]
        |=> cnt[0] == 12'(NORM_N))
        else $error("normal settle delay not loaded");

    settle_end_a: assert property (
        $fell(settle_pending[0]) |-> $past(cnt[0]) == 12'h001)
        else $error("settle flag cleared early");

    settle_hold_a: assert property (
        wr_cfg[1] |=> settle_pending[1] [*8])
        else $error("main settle flag not held");

    raise_reset_a: assert property (
        level_rising && cnt[0] == 12'h001 && !wr_cfg[0]
        && !core_voltage_ok && !(wr_ok && aw_addr == ssmc_pkg::OFF_LEVEL)
        |=> device_reset)
        else $error("missing reset on short core voltage");

    core_off_a: assert property (
        !cfg[0][ssmc_pkg::F_SUP_EN] |=> sup_state[0] == ssmc_pkg::ST_OFF)
        else $error("disabled core supervisor not off");

    auto_deep_a: assert property (
        deep && cfg[0][ssmc_pkg::F_AUTO_CTL] && cfg[0][ssmc_pkg::F_SUP_EN]
        && !cfg[0][ssmc_pkg::F_FAST_PERF] |=> sup_state[0] == ssmc_pkg::ST_OFF)
        else $error("automatic deep state wrong");

    mon_auto_a: assert property (
        deep && cfg[0][ssmc_pkg::F_AUTO_CTL] && cfg[0][ssmc_pkg::F_MON_EN]
        && cfg[0][ssmc_pkg::F_MON_FAST]
        |=> mon_state[0] == ssmc_pkg::ST_NORMAL)
        else $error("core monitor did not drop to normal");

    wake_class_a: assert property (
        ##1 wake_slow == $past(slow_now))
        else $error("wake time class wrong");

    lost_wake_a: assert property (
        deep_entry_s ##0 risky ##1 (!soft_power_up_clear
        && ps == ssmc_pkg::PS_DEEP && wake_irq)
        |=> sleep_stuck && power_mode != ssmc_pkg::PM_ACTIVE_RUN)
        else $error("early interrupt should have been lost");

    puc_clear_a: assert property (
        soft_power_up_clear |=> !sleep_stuck
        && power_mode == ssmc_pkg::PM_ACTIVE_RUN)
        else $error("power-up-clear did not recover");

    safe_wake_a: assert property (
        deep_entry_s ##0 !risky ##1 (!soft_power_up_clear
        && ps == ssmc_pkg::PS_DEEP && wake_irq)
        |=> power_mode == ssmc_pkg::PM_ACTIVE_RUN)
        else $error("safe interrupt did not wake");

endmodule

// [ssmc_top_test.sv]
// self-checking testbench for the supply supervisor mode control block
`timescale 1ns/1ns
module ssmc_top_test;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [1:0] rs;
    logic wake_irq, isr_sleep_req, soft_power_up_clear, core_voltage_ok;
    logic [2:0] isr_sleep_mode;
    logic awready, wready, bvalid, arready, rvalid, wake_slow, device_reset;
    logic sleep_stuck;
    logic [1:0] bresp, rresp, settle_pending, core_level;
    logic [31:0] rdata;
    logic [1:0][1:0] sup_state, mon_state;
    logic [2:0] power_mode;
    int failures = 0, n_tests = 0, resets = 0, n, n2, base;
    logic [7:0] cfgs [8] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0d, 8'h3f,
        8'h2b, 8'h37};
    logic [7:0] c;
    logic [2:0] m;

    ssmc_top ssmc_top_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .wake_irq(wake_irq), .isr_sleep_req(isr_sleep_req),
        .isr_sleep_mode(isr_sleep_mode),
        .soft_power_up_clear(soft_power_up_clear),
        .core_voltage_ok(core_voltage_ok), .sup_state(sup_state),
        .mon_state(mon_state), .settle_pending(settle_pending),
        .wake_slow(wake_slow), .device_reset(device_reset),
        .sleep_stuck(sleep_stuck), .power_mode(power_mode),
        .core_level(core_level));

    initial begin
        aclk = 0;
        forever #20 aclk = ~aclk;
    end

    always @(posedge aclk) if (device_reset === 1'b1) resets++;

    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        bit ad, dd;
        ad = 0;
        dd = 0;
        @(posedge aclk);
        awvalid <= 1;
        awaddr <= a;
        wvalid <= 1;
        wdata <= d;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                ad = 1;
                awvalid <= 0;
            end
            if (wvalid && wready === 1'b1) begin
                dd = 1;
                wvalid <= 0;
            end
        end while (!(ad && dd));
        do @(posedge aclk); while (bvalid !== 1'b1);
        check("bresp", bresp, er);
        bready <= 0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1;
        araddr <= a;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask

    task automatic settle(input int i, output int k);
        k = 0;
        while (settle_pending[i] === 1'b1) begin
            @(posedge aclk);
            k++;
        end
    endtask

    task automatic reset_dut();
        aresetn <= 0;
        tick(3);
        aresetn <= 1;
        tick(1);
    endtask

    task automatic wake();
        wake_irq <= 1;
        tick(2);
        wake_irq <= 0;
        tick(2);
    endtask

    task automatic sleep_wake(input logic [2:0] md);
        isr_sleep_req <= 1;
        isr_sleep_mode <= md;
        tick(1);
        isr_sleep_req <= 0;
        wake();
    endtask

    function automatic logic [1:0] sf(input logic [7:0] c, input bit dp);
        logic [1:0] aw;
        if (!c[ssmc_pkg::F_SUP_EN]) return ssmc_pkg::ST_OFF;
        aw = c[ssmc_pkg::F_FAST_PERF] ? ssmc_pkg::ST_FULL : ssmc_pkg::ST_NORMAL;
        if (!dp) return aw;
        if (!c[ssmc_pkg::F_AUTO_CTL])
            return c[ssmc_pkg::F_SUP_MODE] ? aw : ssmc_pkg::ST_OFF;
        return (c[ssmc_pkg::F_SUP_MODE] && c[ssmc_pkg::F_FAST_PERF]) ?
            ssmc_pkg::ST_NORMAL : ssmc_pkg::ST_OFF;
    endfunction

    function automatic logic [1:0] mf(input logic [7:0] c, input bit dp);
        logic [1:0] aw;
        if (!c[ssmc_pkg::F_MON_EN]) return ssmc_pkg::ST_OFF;
        aw = c[ssmc_pkg::F_MON_FAST] ? ssmc_pkg::ST_FULL : ssmc_pkg::ST_NORMAL;
        if (!dp || !c[ssmc_pkg::F_AUTO_CTL]) return aw;
        return c[ssmc_pkg::F_MON_FAST] ? ssmc_pkg::ST_NORMAL : ssmc_pkg::ST_OFF;
    endfunction

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #(80000 * 40);
        failures++;
        conclude();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        {wake_irq, isr_sleep_req, soft_power_up_clear} = '0;
        isr_sleep_mode = '0;
        core_voltage_ok = 1;
        aresetn = 0;
        tick(3);
        aresetn <= 1;
        tick(1);
        axi_read(ssmc_pkg::OFF_STATUS, rd, rs);
        check("status at reset", rd, 32'h0);
        axi_write(8'h14, 32'h1, ssmc_pkg::RESP_SLVERR);
        axi_read(8'h14, rd, rs);
        check("unmapped data", rd, 32'h0);
        check("unmapped resp", rs, ssmc_pkg::RESP_SLVERR);
        for (int i = 1; i <= 2; i++) begin
            axi_write(ssmc_pkg::OFF_MODE, i, ssmc_pkg::RESP_OKAY);
            tick(1);
            check("light sleep", power_mode, i);
            wake();
            check("light wake", power_mode, 3'h0);
        end
        for (int i = 0; i < 8; i++) begin
            c = cfgs[i];
            m = 3'(3 + i % 3);
            axi_write(ssmc_pkg::OFF_CORE_CTL, c, ssmc_pkg::RESP_OKAY);
            axi_write(ssmc_pkg::OFF_MAIN_CTL, c, ssmc_pkg::RESP_OKAY);
            axi_read(ssmc_pkg::OFF_STATUS, rd, rs);
            check("both pending", rd[1:0], 2'h3);
            settle(0, n);
            settle(1, n2);
            tick(2);
            axi_read(ssmc_pkg::OFF_CORE_CTL, rd, rs);
            check("core ctl", rd, c);
            check("awake", {sup_state, mon_state}, {sf(c, 0), sf(c, 0),
                mf(c, 0), mf(c, 0)});
            check("wake class", wake_slow, (c[0] && !c[2]) ||
                (c[3] && !c[4]));
            if (i % 2 == 0) begin
                axi_write(ssmc_pkg::OFF_MODE, m, ssmc_pkg::RESP_OKAY);
            end else begin
                isr_sleep_req <= 1;
                isr_sleep_mode <= m;
                tick(1);
                isr_sleep_req <= 0;
            end
            tick(30);
            check("deep mode", power_mode, m);
            check("deep", {sup_state, mon_state}, {sf(c, 1), sf(c, 1),
                mf(c, 1), mf(c, 1)});
            wake();
            check("deep wake", {sleep_stuck, power_mode}, 4'h0);
        end
        axi_write(ssmc_pkg::OFF_CORE_CTL, 32'h05, ssmc_pkg::RESP_OKAY);
        settle(0, n);
        check("fast settle", n <= 50 && n >= 45, 1'b1);
        axi_write(ssmc_pkg::OFF_CORE_CTL, 32'h01, ssmc_pkg::RESP_OKAY);
        sleep_wake(3'h3);
        check("stuck", {sleep_stuck, power_mode}, 4'hb);
        soft_power_up_clear <= 1;
        tick(1);
        soft_power_up_clear <= 0;
        tick(2);
        check("clear", {sleep_stuck, power_mode}, 4'h0);
        check("pend kept", settle_pending[0], 1'b1);
        settle(0, n);
        check("normal settle", n > 3700 && n <= 3750, 1'b1);
        for (int j = 0; j < 2; j++) begin
            axi_write(ssmc_pkg::OFF_CORE_CTL, 32'h05, ssmc_pkg::RESP_OKAY);
            axi_write(ssmc_pkg::OFF_MAIN_CTL, 32'h01 + 2 * j,
                ssmc_pkg::RESP_OKAY);
            settle(1, n);
            sleep_wake(3'h4);
            check("main off risk", sleep_stuck, j == 0);
            if (j == 0) begin
                reset_dut();
                check("ext reset", {sleep_stuck, power_mode}, 4'h0);
            end
        end
        axi_write(ssmc_pkg::OFF_CORE_CTL, 32'h05, ssmc_pkg::RESP_OKAY);
        settle(0, n);
        core_voltage_ok <= 0;
        base = resets;
        axi_write(ssmc_pkg::OFF_LEVEL, 32'h1, ssmc_pkg::RESP_OKAY);
        settle(0, n);
        tick(3);
        check("raise fault", resets - base, 1);
        axi_write(ssmc_pkg::OFF_CORE_CTL, 32'h01, ssmc_pkg::RESP_OKAY);
        settle(0, n);
        axi_write(ssmc_pkg::OFF_LEVEL, 32'h2, ssmc_pkg::RESP_OKAY);
        core_voltage_ok <= 1;
        settle(0, n);
        tick(3);
        check("raise ok", resets - base, 1);
        check("level", core_level, 2'h2);
        conclude();
    end
endmodule
